// ### hdl/flash_security_pkg.sv
package flash_security_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_OPTION_WORKING  = 16'h1821;
  localparam logic [15:0] IDX_PROTECT_WORKING = 16'h1824;
  localparam logic [15:0] IDX_FLASH_STATUS    = 16'h1825;
  localparam logic [15:0] IDX_KEY_ENTRY_LO    = 16'h1870;
  localparam logic [15:0] IDX_KEY_ENTRY_HI    = 16'h1871;
  localparam logic [15:0] IDX_KEY_CONTROL     = 16'h1872;
  localparam logic [15:0] IDX_NV_KEY_LO       = 16'hffb0;
  localparam logic [15:0] IDX_NV_KEY_HI       = 16'hffb4;
  localparam logic [15:0] IDX_NV_PROTECT      = 16'hffbd;
  localparam logic [15:0] IDX_NV_TRIM         = 16'hffbe;
  localparam logic [15:0] IDX_NV_OPTION       = 16'hffbf;

  // option byte fields
  localparam int OPT_KEY_ENABLE_BIT = 7;
  localparam int OPT_REDIRECT_BIT   = 6;
  localparam int OPT_SEC_HI_BIT     = 1;
  localparam int OPT_SEC_LO_BIT     = 0;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;

  // protection byte fields
  localparam int PROT_DISABLE_BIT = 0;

  // status fields
  localparam int STAT_ACCESS_ERROR_BIT = 4;
  localparam int STAT_BLANK_BIT        = 2;

  // key control fields
  localparam int KCTL_COMPARE_BIT  = 0;
  localparam int KCTL_UNLOCKED_BIT = 1;
  localparam int KCTL_ENABLED_BIT  = 2;

  // reset values of working registers
  localparam logic [7:0] PROTECT_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET  = 8'h00;
  localparam logic [63:0] KEY_RESET    = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h1,
    ST_RUN  = 2'h2
  } unit_state_t;

endpackage : flash_security_pkg

// ### hdl/reg_access_if.sv
`timescale 1ns/1ps
interface reg_access_if;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] index;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;

  modport bus (
    output wr_en,
    output rd_en,
    output index,
    output wdata,
    input  rdata,
    input  hit
  );

  modport regs (
    input  wr_en,
    input  rd_en,
    input  index,
    input  wdata,
    output rdata,
    output hit
  );
endinterface : reg_access_if

// ### hdl/apb_reg_port.sv
`timescale 1ns/1ps
module apb_reg_port (
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  psel,
  input  wire logic  penable,
  input  wire logic  pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic       pready,
  output logic [31:0] prdata,
  output logic       pslverr,
  reg_access_if.bus  ra
);
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;
  logic        err_q;
  logic        next_err;
  logic        setup;
  logic        access;

  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign ra.index = paddr[17:2];
  assign ra.wdata = pwdata;
  assign ra.rd_en = setup & ~pwrite;
  // write lands at the completing edge of the access phase
  assign ra.wr_en = access & pwrite & ~err_q;
  assign pready   = 1'b1;
  assign prdata   = rdata_q;
  assign pslverr  = access & err_q;

  always_comb begin
    next_rdata = rdata_q;
    next_err   = err_q;
    if (setup) begin
      next_err   = ~ra.hit | (paddr[1:0] != 2'h0);
      next_rdata = 32'h0000_0000;
    end
    // read data captured only on a read setup
    if (ra.rd_en) begin
      next_rdata = ra.rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= next_rdata;
      err_q   <= next_err;
    end
  end
endmodule : apb_reg_port

// ### hdl/backdoor_key_compare.sv
`timescale 1ns/1ps
module backdoor_key_compare #(
  parameter int KEY_BYTES = 8
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   load_lo,
  input  wire logic                   load_hi,
  input  wire logic [31:0]            wdata,
  input  wire logic [KEY_BYTES*8-1:0] stored_key,
  input  wire logic                   compare,
  output logic [KEY_BYTES*8-1:0]      entered_key,
  output logic                        match
);
  logic [KEY_BYTES*8-1:0] key_q;
  logic [KEY_BYTES*8-1:0] next_key;
  logic                   match_q;
  logic                   next_match;
  logic [KEY_BYTES-1:0]   byte_eq;

  genvar g;
  generate
    for (g = 0; g < KEY_BYTES; g++) begin : g_byte
      assign byte_eq[g] = key_q[g*8 +: 8] == stored_key[g*8 +: 8];
    end
  endgenerate

  always_comb begin
    next_key = key_q;
    if (load_lo) next_key[31:0] = wdata;
    if (load_hi) next_key[63:32] = wdata;
    next_match = compare & (&byte_eq);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q   <= flash_security_pkg::KEY_RESET;
      match_q <= 1'b0;
    end else begin
      key_q   <= next_key;
      match_q <= next_match;
    end
  end

  assign entered_key = key_q;
  assign match       = match_q;
endmodule : backdoor_key_compare

// ### hdl/flash_security_key_unit.sv
// Behaviour
// - reset copies nonvolatile protect/option into working
// - eight-byte key unlocks only when key enabled
// - key entry only from secure code, never debug
// - key disabled: only erase plus blank unlocks
// - security field 1:0 alone means unsecured
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module flash_security_key_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  nonvolatile_protect_byte,
  input  wire logic [7:0]  nonvolatile_option_byte,
  input  wire logic [7:0]  nonvolatile_oscillator_trim,
  input  wire logic [63:0] backdoor_compare_key,
  input  wire logic        exec_from_secure,
  input  wire logic        debug_access,
  input  wire logic        mass_erase_done,
  input  wire logic        blank_check_pass,
  output logic             security_engaged,
  output logic [7:0]       flash_protect_working,
  output logic [7:0]       flash_option_working,
  output logic             protection_disable,
  output logic             vector_redirect_disable,
  output logic             load_done
);
  reg_access_if ra ();

  flash_security_pkg::unit_state_t state;
  flash_security_pkg::unit_state_t next_state;

  // working copies and sticky unlock state
  logic [7:0] prot_q;
  logic [7:0] next_prot;
  logic [7:0] opt_q;
  logic [7:0] next_opt;
  logic       key_unlocked;
  logic       next_key_unlocked;
  logic       erase_seen;
  logic       next_erase_seen;
  logic       blank_unlocked;
  logic       next_blank_unlocked;
  logic       access_error;
  logic       next_access_error;

  // key path decode and security terms
  logic        key_enabled;
  logic        entry_allowed;
  logic        wr_key_lo;
  logic        wr_key_hi;
  logic        wr_ctrl;
  logic        wr_status;
  logic        key_write_try;
  logic        load_lo;
  logic        load_hi;
  logic        compare;
  logic        match;
  logic        field_unsecured;
  logic [63:0] entered_key;
  logic        run_state;
  logic        loaded_unsecured;
  logic        key_path_open;
  logic        erase_path_open;
  logic        sel_key_lo;
  logic        sel_key_hi;
  logic        sel_ctrl;
  logic        sel_status;
  logic        status_clear;
  logic        refused_try;
  logic        blank_event;

  apb_reg_port u_port (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .ra      (ra.bus)
  );

  // compare result lands on the same edge as the compare write
  backdoor_key_compare #(
    .KEY_BYTES (8)
  ) u_key (
    .pclk        (pclk),
    .presetn     (presetn),
    .load_lo     (load_lo),
    .load_hi     (load_hi),
    .wdata       (ra.wdata),
    .stored_key  (backdoor_compare_key),
    .compare     (compare),
    .entered_key (entered_key),
    .match       (match)
  );

  // working option byte governs key enable and security field
  assign key_enabled = opt_q[flash_security_pkg::OPT_KEY_ENABLE_BIT];
  // debug-driven bus cycles never reach the key path
  assign run_state     = state == flash_security_pkg::ST_RUN;
  assign entry_allowed = key_enabled
                         & exec_from_secure
                         & ~debug_access
                         & run_state;

  // one select per key-side register
  assign sel_key_lo = ra.index == flash_security_pkg::IDX_KEY_ENTRY_LO;
  assign sel_key_hi = ra.index == flash_security_pkg::IDX_KEY_ENTRY_HI;
  assign sel_ctrl   = ra.index == flash_security_pkg::IDX_KEY_CONTROL;
  assign sel_status = ra.index == flash_security_pkg::IDX_FLASH_STATUS;

  assign wr_key_lo = ra.wr_en & sel_key_lo;
  assign wr_key_hi = ra.wr_en & sel_key_hi;
  assign wr_ctrl   = ra.wr_en & sel_ctrl;
  assign wr_status = ra.wr_en & sel_status;

  // a key entry word write, or a control write with the compare bit set, counts as an entry attempt
  assign key_write_try = wr_key_lo
                         | wr_key_hi
                         | (wr_ctrl
                            & ra.wdata[flash_security_pkg::KCTL_COMPARE_BIT]);
  assign load_lo = wr_key_lo & entry_allowed;
  assign load_hi = wr_key_hi & entry_allowed;
  assign compare = wr_ctrl & entry_allowed
                   & ra.wdata[flash_security_pkg::KCTL_COMPARE_BIT];

  assign field_unsecured =
    {opt_q[flash_security_pkg::OPT_SEC_HI_BIT],
     opt_q[flash_security_pkg::OPT_SEC_LO_BIT]}
    == flash_security_pkg::SEC_UNSECURED;

  // secured until loading completes; any other field value stays secured
  assign loaded_unsecured = field_unsecured & run_state;
  // either unlock path lifts security until the next reset
  assign key_path_open    = key_unlocked;
  assign erase_path_open  = blank_unlocked;
  assign security_engaged = ~loaded_unsecured
                            & ~key_path_open
                            & ~erase_path_open;

  // write-one-clear request for the access error flag
  assign status_clear = wr_status
                        & ra.wdata[flash_security_pkg::STAT_ACCESS_ERROR_BIT];
  // key entry attempt made while entry is refused
  assign refused_try  = key_write_try & ~entry_allowed;
  // blank pass counts only after an erase has been seen
  assign blank_event  = blank_check_pass & erase_seen;

  // load group: working copies taken once after reset
  always_comb begin
    next_state = state;
    next_prot  = prot_q;
    next_opt   = opt_q;
    case (state)
      flash_security_pkg::ST_LOAD: begin
        // first edge after release copies nonvolatile bytes
        next_prot  = nonvolatile_protect_byte;
        next_opt   = nonvolatile_option_byte;
        next_state = flash_security_pkg::ST_RUN;
      end
      flash_security_pkg::ST_RUN: begin
        next_state = flash_security_pkg::ST_RUN;
      end
      default: begin
        next_state = flash_security_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state  <= flash_security_pkg::ST_LOAD;
      prot_q <= flash_security_pkg::PROTECT_RESET;
      opt_q  <= flash_security_pkg::OPTION_RESET;
    end else begin
      state  <= next_state;
      prot_q <= next_prot;
      opt_q  <= next_opt;
    end
  end

  // unlock group: held until reset reloads the option byte
  always_comb begin
    next_key_unlocked   = key_unlocked;
    next_erase_seen     = erase_seen;
    next_blank_unlocked = blank_unlocked;
    if (run_state) begin
      if (match) begin
        next_key_unlocked = 1'b1;
      end
      if (mass_erase_done) begin
        next_erase_seen = 1'b1;
      end
      if (blank_event) begin
        next_blank_unlocked = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_unlocked   <= 1'b0;
      erase_seen     <= 1'b0;
      blank_unlocked <= 1'b0;
    end else begin
      key_unlocked   <= next_key_unlocked;
      erase_seen     <= next_erase_seen;
      blank_unlocked <= next_blank_unlocked;
    end
  end

  // status group: a refused attempt beats a clear in the same cycle
  always_comb begin
    next_access_error = access_error;
    if (run_state) begin
      if (status_clear) begin
        next_access_error = 1'b0;
      end
      if (refused_try) begin
        next_access_error = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_error <= 1'b0;
    end else begin
      access_error <= next_access_error;
    end
  end

  // register read map
  always_comb begin
    ra.hit   = 1'b1;
    ra.rdata = 32'h0000_0000;
    case (ra.index)
      flash_security_pkg::IDX_OPTION_WORKING: begin
        ra.rdata[7:0] = opt_q;
      end
      flash_security_pkg::IDX_PROTECT_WORKING: begin
        ra.rdata[7:0] = prot_q;
      end
      flash_security_pkg::IDX_FLASH_STATUS: begin
        ra.rdata[flash_security_pkg::STAT_ACCESS_ERROR_BIT] = access_error;
        ra.rdata[flash_security_pkg::STAT_BLANK_BIT]        = blank_unlocked;
      end
      // write-only key entry words read back as zero
      flash_security_pkg::IDX_KEY_ENTRY_LO: begin
        ra.rdata = 32'h0000_0000;
      end
      flash_security_pkg::IDX_KEY_ENTRY_HI: begin
        ra.rdata = 32'h0000_0000;
      end
      flash_security_pkg::IDX_KEY_CONTROL: begin
        ra.rdata[flash_security_pkg::KCTL_UNLOCKED_BIT] = key_unlocked;
        ra.rdata[flash_security_pkg::KCTL_ENABLED_BIT]  = key_enabled;
      end
      // stored key hidden while secured
      flash_security_pkg::IDX_NV_KEY_LO: begin
        ra.rdata = security_engaged ? 32'h0000_0000
                                    : backdoor_compare_key[31:0];
      end
      flash_security_pkg::IDX_NV_KEY_HI: begin
        ra.rdata = security_engaged ? 32'h0000_0000
                                    : backdoor_compare_key[63:32];
      end
      flash_security_pkg::IDX_NV_PROTECT: begin
        ra.rdata[7:0] = nonvolatile_protect_byte;
      end
      // trim readable so software can save it before erase
      flash_security_pkg::IDX_NV_TRIM: begin
        ra.rdata[7:0] = nonvolatile_oscillator_trim;
      end
      flash_security_pkg::IDX_NV_OPTION: begin
        ra.rdata[7:0] = nonvolatile_option_byte;
      end
      default: begin
        ra.hit = 1'b0;
      end
    endcase
  end

  // data outputs straight from the working registers; load_done from the state
  assign flash_protect_working   = prot_q;
  assign flash_option_working    = opt_q;
  assign protection_disable      = prot_q[flash_security_pkg::PROT_DISABLE_BIT];
  assign vector_redirect_disable = opt_q[flash_security_pkg::OPT_REDIRECT_BIT];
  assign load_done               = run_state;
endmodule : flash_security_key_unit

// ### verification/flash_security_key_unit_monitor.sv
`timescale 1ns/1ps
module flash_security_key_unit_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       security_engaged,
  input wire logic [7:0] flash_protect_working,
  input wire logic [7:0] flash_option_working,
  input wire logic       protection_disable,
  input wire logic       vector_redirect_disable,
  input wire logic       load_done,
  input wire logic [7:0] nonvolatile_protect_byte,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic       blank_check_pass
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  nv_load_a: assert property (
    $rose(load_done) |-> flash_protect_working == nonvolatile_protect_byte
      && flash_option_working == nonvolatile_option_byte)
    else $error("working copies differ from nonvolatile bytes");
  field_map_a: assert property (
    load_done |-> protection_disable == flash_protect_working[0]
      && vector_redirect_disable == flash_option_working[6])
    else $error("protection or redirect output off its working bit");
  preload_a: assert property (
    !load_done |-> security_engaged)
    else $error("unsecured before working copies loaded");
  unsec_a: assert property (
    load_done && flash_option_working[1:0] == 2'b10 |-> !security_engaged)
    else $error("security engaged with unsecured pattern");
  key_gate_a: assert property (
    $fell(security_engaged) && flash_option_working[1:0] != 2'b10
      |-> flash_option_working[7] || $past(blank_check_pass))
    else $error("security lifted by key while key disabled");
  erase_only_a: assert property (
    load_done && !flash_option_working[7]
      && flash_option_working[1:0] != 2'b10 && $past(security_engaged)
      && !$past(blank_check_pass) |-> security_engaged)
    else $error("security lifted without blank pass");
  unlock_hold_a: assert property (
    !security_engaged |=> !security_engaged)
    else $error("unlock lost before reset");
endmodule : flash_security_key_unit_monitor

bind flash_security_key_unit flash_security_key_unit_monitor mon (
  .pclk(pclk), .presetn(presetn), .security_engaged(security_engaged),
  .flash_protect_working(flash_protect_working),
  .flash_option_working(flash_option_working),
  .protection_disable(protection_disable),
  .vector_redirect_disable(vector_redirect_disable),
  .load_done(load_done),
  .nonvolatile_protect_byte(nonvolatile_protect_byte),
  .nonvolatile_option_byte(nonvolatile_option_byte),
  .blank_check_pass(blank_check_pass));

// ### verification/test_flash_security_key_unit.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module test_flash_security_key_unit;
  localparam logic [63:0] KEY = 64'h0123_4567_89ab_cdef;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = 18'h0_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [7:0]  nv_opt = 8'h00;
  logic        sec_x = 1'b1;
  logic        dbg = 1'b0;
  logic        erased = 1'b0;
  logic        blank = 1'b0;
  logic        pready, pslverr, engaged, prot_dis, redir, loaded, err;
  logic [31:0] prdata, rd;
  logic [7:0]  prot_w, opt_w;
  int          error_cnt = 0;
  int          n_tests = 0;

  always #4 pclk = ~pclk;

  flash_security_key_unit dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .nonvolatile_protect_byte(8'h81), .nonvolatile_option_byte(nv_opt),
    .nonvolatile_oscillator_trim(8'h5a), .backdoor_compare_key(KEY),
    .exec_from_secure(sec_x), .debug_access(dbg),
    .mass_erase_done(erased), .blank_check_pass(blank),
    .security_engaged(engaged), .flash_protect_working(prot_w),
    .flash_option_working(opt_w), .protection_disable(prot_dis),
    .vector_redirect_disable(redir), .load_done(loaded));

  task automatic apb(input logic w, input logic [15:0] i,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rst(input logic [7:0] opt);
    presetn <= 1'b0;
    nv_opt <= opt;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : rst

  task automatic key(input logic [63:0] k);
    apb(1'b1, flash_security_pkg::IDX_KEY_ENTRY_LO, k[31:0]);
    apb(1'b1, flash_security_pkg::IDX_KEY_ENTRY_HI, k[63:32]);
    apb(1'b1, flash_security_pkg::IDX_KEY_CONTROL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
  endtask : key

  task automatic t_load;
    rst(8'h43);
    `CHK("loaded", 1'b1, loaded)
    `CHK("prot", 8'h81, prot_w)
    `CHK("opt", 8'h43, opt_w)
    `CHK("fields", 2'b11, {prot_dis, redir})
    apb(1'b1, flash_security_pkg::IDX_OPTION_WORKING, 32'h0000_0000);
    apb(1'b0, flash_security_pkg::IDX_OPTION_WORKING, 32'h0000_0000);
    `CHK("rd opt", 32'h0000_0043, rd)
    apb(1'b0, flash_security_pkg::IDX_PROTECT_WORKING, 32'h0000_0000);
    `CHK("rd prot", 32'h0000_0081, rd)
    apb(1'b0, flash_security_pkg::IDX_NV_OPTION, 32'h0000_0000);
    `CHK("nv opt", 32'h0000_0043, rd)
    apb(1'b0, flash_security_pkg::IDX_NV_PROTECT, 32'h0000_0000);
    `CHK("nv prot", 32'h0000_0081, rd)
    apb(1'b0, 16'h1234, 32'h0000_0000);
    `CHK("unmapped", 1'b1, err)
  endtask : t_load

  task automatic t_sec;
    for (int s = 0; s < 4; s++) begin
      rst({6'h00, s[1:0]});
      `CHK("sec", s != 2, engaged)
    end
  endtask : t_sec

  task automatic t_key;
    rst(8'h80);
    sec_x <= 1'b0;
    key(KEY);
    `CHK("outside", 1'b1, engaged)
    sec_x <= 1'b1;
    dbg <= 1'b1;
    key(KEY);
    `CHK("debug", 1'b1, engaged)
    dbg <= 1'b0;
    apb(1'b0, flash_security_pkg::IDX_FLASH_STATUS, 32'h0000_0000);
    `CHK("acc err", 1'b1, rd[4])
    apb(1'b1, flash_security_pkg::IDX_FLASH_STATUS, 32'h0000_0010);
    key(~KEY);
    `CHK("wrong", 1'b1, engaged)
    apb(1'b0, flash_security_pkg::IDX_FLASH_STATUS, 32'h0000_0000);
    `CHK("acc clr", 1'b0, rd[4])
    apb(1'b0, flash_security_pkg::IDX_NV_KEY_LO, 32'h0000_0000);
    `CHK("hidden", 32'h0000_0000, rd)
    key(KEY);
    `CHK("match", 1'b0, engaged)
    apb(1'b0, flash_security_pkg::IDX_NV_KEY_LO, 32'h0000_0000);
    `CHK("key lo", KEY[31:0], rd)
    apb(1'b0, flash_security_pkg::IDX_NV_KEY_HI, 32'h0000_0000);
    `CHK("key hi", KEY[63:32], rd)
    apb(1'b0, flash_security_pkg::IDX_KEY_CONTROL, 32'h0000_0000);
    `CHK("kctl", 32'h0000_0006, rd)
    rst(8'h80);
    `CHK("relock", 1'b1, engaged)
  endtask : t_key

  task automatic t_erase;
    rst(8'h00);
    apb(1'b0, flash_security_pkg::IDX_NV_TRIM, 32'h0000_0000);
    `CHK("trim", 32'h0000_005a, rd)
    key(KEY);
    `CHK("key off", 1'b1, engaged)
    blank <= 1'b1;
    @(posedge pclk);
    blank <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("no erase", 1'b1, engaged)
    erased <= 1'b1;
    @(posedge pclk);
    erased <= 1'b0;
    @(posedge pclk);
    blank <= 1'b1;
    @(posedge pclk);
    blank <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("erased", 1'b0, engaged)
    apb(1'b0, flash_security_pkg::IDX_FLASH_STATUS, 32'h0000_0000);
    `CHK("blank", 1'b1, rd[2])
    rst(8'h00);
    `CHK("relock", 1'b1, engaged)
  endtask : t_erase

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    t_load();
    t_sec();
    t_key();
    t_erase();
    wrap_up();
  end
endmodule : test_flash_security_key_unit
